// File: otpp_pkg.sv
/*
 * Shared constants for the one-time PROM program port: array geometry,
 * clock rate, program pulse timing and the program sequencer state encoding.
 * Assumes a single 40 MHz system clock standing in for the resonator.
 */
package otpp_pkg;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DEPTH = 16384;
   localparam int unsigned HI_ADDR_W = 2;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   // Clock rate and program pulse width
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned PGM_PULSE_US = 1000;
   localparam int unsigned PGM_CYCLES = (PGM_PULSE_US * CLK_KHZ) / 1000;
   localparam int unsigned CNT_W = 17;
   // Clock output divides by four: toggle every second cycle
   localparam logic [0:0] DIV_LAST = 1'h1;
   // Program sequencer states, one-hot
   typedef enum logic [2:0] {
      OTPP_IDLE = 3'h1,
      OTPP_PULSE = 3'h2,
      OTPP_HOLD = 3'h4
   } otpp_state_e;
endpackage

// File: otpp_clkdiv.sv
/*
 * Clock-output divider: a square wave at one quarter of clk_sys,
 * held high while run is low so the pin rests at its pulled-up level.
 * Assumes run is synchronous to clk_sys.
 */
`timescale 1ns/10ps
module otpp_clkdiv (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire logic run,
   // Divided clock
   output logic clk_div
);
   typedef struct packed {
      logic [0:0] phase;
      logic wave;
   } otpp_div_s;

   otpp_div_s st;
   otpp_div_s next_st;

   always_comb begin
      next_st = st;
      if (!run) begin
         next_st.phase = '0;
         next_st.wave = 1'b1;
      end else if (st.phase == otpp_pkg::DIV_LAST) begin
         next_st.phase = '0;
         next_st.wave = ~st.wave;
      end else begin
         next_st.phase = st.phase + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{phase: '0, wave: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign clk_div = st.wave;

   quarter_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      run && $past(run) && $past(run, 2) && $changed(clk_div)
         |-> ##1 $stable(clk_div) ##1 ($changed(clk_div) || !$past(run)))
      else $error("clock output not at quarter rate");
endmodule // otpp_clkdiv

// File: otpp_prog_port.sv
/*
 * Mode selection and byte-wide program/verify port of the internal
 * one-time PROM. Holds the 16K x 8 array itself.
 * Assumes an external programmer drives address, data and strobes
 * synchronously to clk_sys, and that the bench models the pull-up on the clock pin.
 */
`timescale 1ns/10ps
module otpp_prog_port #(
   parameter int unsigned PGM_CYCLES = otpp_pkg::PGM_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Mode pins
   input wire logic reset_pin_n,
   input wire logic clk_pin_in,
   output logic clk_pin_out,
   output logic clk_pin_oe,
   input wire logic external_fetch_select,
   // Programmer address and strobes
   input wire logic [otpp_pkg::ADDR_W-1:0] addr,
   input wire logic [otpp_pkg::HI_ADDR_W-1:0] addr_hi,
   input wire logic ce_n,
   input wire logic oe_n,
   // Data pins
   input wire logic [otpp_pkg::DATA_W-1:0] data_in,
   output logic [otpp_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   // Mode status
   output logic prom_mode,
   output logic normal_mode,
   output logic fetch_internal
);
   localparam logic [otpp_pkg::CNT_W-1:0] PGM_LAST = otpp_pkg::CNT_W'(PGM_CYCLES - 1);

   typedef struct packed {
      otpp_pkg::otpp_state_e state;
      logic [otpp_pkg::CNT_W-1:0] cnt;
      logic [otpp_pkg::DATA_W-1:0] rd_data;
      logic prom;
      logic fetch_int;
   } otpp_port_s;

   otpp_port_s st;
   otpp_port_s next_st;
   logic [otpp_pkg::DATA_W-1:0] rom [otpp_pkg::DEPTH];
   logic wr_en;
   logic clk_div;
   logic mode_req;

   // Erased array reads all ones; programming only clears bits
   initial begin
      for (int i = 0; i < otpp_pkg::DEPTH; i++) begin
         rom[i] = otpp_pkg::ERASED_BYTE;
      end
   end

   assign mode_req = !reset_pin_n && !clk_pin_in;

   always_comb begin
      next_st = st;
      wr_en = 1'b0;
      next_st.prom = mode_req;
      next_st.fetch_int = external_fetch_select;
      // Array contents only, no signature mux
      next_st.rd_data = rom[addr];
      case (st.state)
         otpp_pkg::OTPP_IDLE: begin
            next_st.cnt = '0;
            if (st.prom && !ce_n && oe_n) begin
               next_st.state = otpp_pkg::OTPP_PULSE;
            end
         end
         otpp_pkg::OTPP_PULSE: begin
            // A pulse cut short programs nothing
            if (!st.prom || ce_n || !oe_n) begin
               next_st.state = otpp_pkg::OTPP_IDLE;
            end else if (st.cnt == PGM_LAST) begin
               wr_en = 1'b1;
               next_st.state = otpp_pkg::OTPP_HOLD;
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         otpp_pkg::OTPP_HOLD: begin
            // One commit per strobe; longer over-program pulses are harmless
            if (!st.prom || ce_n) begin
               next_st.state = otpp_pkg::OTPP_IDLE;
            end
         end
         default: begin
            next_st.state = otpp_pkg::OTPP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{state: otpp_pkg::OTPP_IDLE, cnt: '0, rd_data: otpp_pkg::ERASED_BYTE,
                 prom: 1'b0, fetch_int: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // Plain always: the erasing initial block writes the array too
   always @(posedge clk_sys) begin
      if (wr_en) begin
         rom[addr] <= rom[addr] & data_in;
      end
   end

   otpp_clkdiv u_clkdiv (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(reset_pin_n),
      .clk_div(clk_div)
   );

   // Pin released during reset so the programmer can pull it low
   assign clk_pin_oe = reset_pin_n;
   assign clk_pin_out = clk_div;
   assign data_oe = st.prom && !ce_n && !oe_n;
   assign data_out = st.rd_data;
   assign prom_mode = st.prom;
   assign normal_mode = !st.prom;
   assign fetch_internal = st.fetch_int;

   mode_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      prom_mode |-> $past(!reset_pin_n && !clk_pin_in))
      else $error("prom mode without both pins low");
   normal_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reset_pin_n |-> clk_pin_oe ##1 normal_mode)
      else $error("clock pin not driven in normal mode");
   reset_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reset_pin_n |-> !clk_pin_oe ##1 clk_pin_out)
      else $error("clock pin not released high during reset");
   fetch_strap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 fetch_internal == $past(external_fetch_select))
      else $error("fetch select does not follow strap");
   pgm_commit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en |-> st.state == otpp_pkg::OTPP_PULSE && st.cnt == PGM_LAST && !ce_n && prom_mode)
      else $error("byte committed outside a full program pulse");
   pgm_effect_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_en |=> st.state == otpp_pkg::OTPP_HOLD ##0 rom[$past(addr)] == ($past(rom[addr]) & $past(data_in)))
      else $error("programmed byte wrong");
   no_signature_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      data_oe && $stable(addr) |-> data_out == rom[addr] || $past(wr_en))
      else $error("data pins show something other than the array");
   data_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      data_oe |-> !ce_n && !oe_n && prom_mode)
      else $error("data pins driven without both strobes");

   // Sequencer checks: entry, counting, cut pulses, the single commit and hold exit; then mode entry and read data
   property pulse_start_p;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(st.state == otpp_pkg::OTPP_PULSE) |-> st.cnt == '0 && $past(prom_mode && !ce_n && oe_n);
   endproperty
   pulse_start_a: assert property (pulse_start_p)
      else $error("program pulse started without a clean strobe");

   property pulse_count_p;
      @(posedge clk_sys) disable iff (!rst_n)
      st.state == otpp_pkg::OTPP_PULSE && $past(st.state) == otpp_pkg::OTPP_PULSE
         |-> st.cnt == $past(st.cnt) + 1'b1;
   endproperty
   pulse_count_a: assert property (pulse_count_p)
      else $error("pulse counter skipped a cycle");

   property cut_pulse_p;
      @(posedge clk_sys) disable iff (!rst_n)
      st.state == otpp_pkg::OTPP_PULSE && (ce_n || !oe_n || !prom_mode)
         |-> !wr_en ##1 st.state == otpp_pkg::OTPP_IDLE;
   endproperty
   cut_pulse_a: assert property (cut_pulse_p)
      else $error("cut program pulse was not discarded");

   property one_commit_p;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_en |=> !wr_en;
   endproperty
   one_commit_a: assert property (one_commit_p)
      else $error("more than one commit for one strobe");

   property hold_exit_p;
      @(posedge clk_sys) disable iff (!rst_n)
      st.state == otpp_pkg::OTPP_HOLD && (ce_n || !prom_mode) |=> st.state == otpp_pkg::OTPP_IDLE;
   endproperty
   hold_exit_a: assert property (hold_exit_p)
      else $error("sequencer stuck after strobe release");

   property mode_follow_p;
      @(posedge clk_sys) disable iff (!rst_n)
      $past(mode_req) && $past(rst_n) |-> prom_mode;
   endproperty
   mode_follow_a: assert property (mode_follow_p)
      else $error("prom mode not entered with both pins low");

   property read_latency_p;
      @(posedge clk_sys) disable iff (!rst_n)
      data_oe |-> data_out == $past(rom[addr]);
   endproperty
   read_latency_a: assert property (read_latency_p)
      else $error("data pins not showing the addressed byte");

   cover_prom_entry: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(prom_mode));
   cover_program: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_en);
   cover_verify_read: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(data_oe));
   cover_short_pulse: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st.state == otpp_pkg::OTPP_PULSE ##1 st.state == otpp_pkg::OTPP_IDLE);
   cover_over_program: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st.state == otpp_pkg::OTPP_HOLD ##1 st.state == otpp_pkg::OTPP_HOLD);
endmodule // otpp_prog_port

// File: otpp_programmer.sv
/* Behavioural PROM programmer on the far side of the program port.
   Assumes its inputs are the resolved data pins, and it acts at the falling edge of clk_sys. */
`timescale 1ns/10ps
module otpp_programmer #(
   parameter int unsigned PULSE = 22
) (
   // Clock
   input wire logic clk_sys,
   // Resolved data pins
   input wire logic [7:0] pin_data,
   // Address, strobes and data drive
   output logic [13:0] addr,
   output logic ce_n,
   output logic oe_n,
   output logic [7:0] data
);
   initial begin
      addr = 14'h0000;
      ce_n = 1'b1;
      oe_n = 1'b1;
      data = 8'h5A;
   end
   task automatic wr(input logic [13:0] a, input logic [7:0] d, input int unsigned n);
      @(negedge clk_sys);
      addr = a;
      data = d;
      @(negedge clk_sys);
      ce_n = 1'b0;
      repeat (n) @(negedge clk_sys);
      ce_n = 1'b1;
      @(negedge clk_sys);
      data = ~d; // Stale value would hide a missed sample
   endtask
   task automatic rd(input logic [13:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      addr = a;
      ce_n = 1'b0;
      oe_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      d = pin_data;
      ce_n = 1'b1;
      oe_n = 1'b1;
   endtask
   // No signature query: plain reads only
   task automatic prog(input logic [13:0] a, input logic [7:0] d, output logic ok);
      int unsigned k;
      logic [7:0] q;
      ok = 1'b0;
      k = 0;
      while (k < 25 && !ok) begin
         wr(a, d, PULSE);
         rd(a, q);
         ok = (q === d);
         k++;
      end
      if (ok) begin
         wr(a, d, 3 * k * PULSE);
         rd(a, q);
         ok = (q === d);
      end
   endtask
endmodule // otpp_programmer

// File: tb_top.sv
/* Self-checking bench for the program port with the programmer model.
   Assumes PGM_CYCLES of 20; the bench stands for the pull-up and adapter socket. */
`timescale 1ns/10ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin_n = 1'b1;
   logic clk_low = 1'b0;
   logic external_fetch_select = 1'b1;
   logic clk_pin_out, clk_pin_oe, data_oe, prom_mode, normal_mode, fetch_internal, ce_n, oe_n, ok, c, exp_ok;
   logic [13:0] addr, a;
   logic [7:0] prg_data, data_out, d, q;
   logic [31:0] seed = 32'h00000A64;
   logic [7:0] shadow [logic [13:0]];
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   // Pull-up on the clock pin unless the socket holds it low
   wire logic clk_pin_in = clk_pin_oe ? clk_pin_out : !clk_low;
   wire logic [7:0] data_in = data_oe ? data_out : prg_data;
   always #12.5 clk_sys = ~clk_sys;
   otpp_prog_port #(.PGM_CYCLES(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
      .clk_pin_in(clk_pin_in), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
      .external_fetch_select(external_fetch_select), .addr(addr), .addr_hi(2'h0), .ce_n(ce_n), .oe_n(oe_n),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .prom_mode(prom_mode),
      .normal_mode(normal_mode), .fetch_internal(fetch_internal));
   otpp_programmer #(.PULSE(22)) i_prg (.clk_sys(clk_sys), .pin_data(data_in), .addr(addr), .ce_n(ce_n),
      .oe_n(oe_n), .data(prg_data));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] expect_byte(input logic [13:0] k);
      return shadow.exists(k) ? shadow[k] : 8'hFF;
   endfunction
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
         n_fail++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      chk("normal_mode", normal_mode, 8'h01);
      chk("clk_pin_oe", clk_pin_oe, 8'h01);
      for (int i = 0; i < 4; i++) begin
         c = clk_pin_out;
         repeat (2) @(negedge clk_sys);
         chk("clk_pin_out", clk_pin_out, !c);
         external_fetch_select = rnd() > 32'h7FFFFFFF;
         @(negedge clk_sys);
         chk("fetch_internal", fetch_internal, external_fetch_select);
      end
      $display("normal mode test done");
      reset_pin_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("clk_pin_hi", {clk_pin_oe, clk_pin_out}, 8'h01);
      chk("prom_mode", prom_mode, 8'h00);
      clk_low = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("prom_mode", prom_mode, 8'h01);
      chk("data_oe", data_oe, 8'h00);
      for (int i = 0; i < 8; i++) begin
         a = 14'((i == 0) ? 32'h00000000 : (rnd() & 32'h00001FFF));
         d = 8'(rnd());
         exp_ok = (expect_byte(a) & d) == d;
         i_prg.prog(a, d, ok);
         shadow[a] = expect_byte(a) & d;
         chk("prog_ok", ok, exp_ok);
      end
      i_prg.prog(14'h0000, 8'hFF, ok);
      chk("refused_ok", ok, (shadow[14'h0000] == 8'hFF));
      i_prg.wr(14'h2000, 8'h00, 10);
      i_prg.rd(14'h2000, q);
      chk("short_pulse", q, 8'hFF);
      i_prg.rd(14'h3FFF, q);
      chk("no_signature", q, 8'hFF);
      @(negedge clk_sys);
      chk("data_oe", data_oe, 8'h00);
      $display("program test done");
      foreach (shadow[k]) begin
         i_prg.rd(k, q);
         chk("final_verify", q, shadow[k]);
      end
      $display("verify test done");
      reset_pin_n = 1'b1;
      clk_low = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("leave_prom", {prom_mode, normal_mode}, 8'h01);
      $display("mode exit test done");
      report_and_stop();
   end
endmodule // tb_top
